// [src/lrd_regs.svh]
// Constants for the dual channel light readout
`ifndef LRD_REGS_SVH
`define LRD_REGS_SVH
// Integration timing, in oscillator cycles
`define LRD_CYC_UNIT 19'd918
`define LRD_MULT_00 19'd11
`define LRD_MULT_01 19'd81
`define LRD_MULT_10 19'd322
// Count limits
`define LRD_CNT_OFFSET 18'd2
`define LRD_CNT_MAX 18'h0FFFF
`define LRD_PRESCALE_LAST 4'hF
// Bus addresses
`define LRD_ARA_ADDR 7'h0C
`define LRD_ADDR_GND 7'h29
`define LRD_ADDR_FLOAT 7'h39
`define LRD_ADDR_VDD 7'h49
// Register select values and reset
`define LRD_SEL_RESET 4'h0
`define LRD_REG_D0L 4'hC
`define LRD_REG_D0H 4'hD
`define LRD_REG_D1L 4'hE
`define LRD_REG_D1H 4'hF
// Bus timeout
`define LRD_CLK_KHZ 10000
`define LRD_TIMEOUT_MS 25
`endif

// [src/lrd_pkg.sv]
// Types for the dual channel light readout
package lrd_pkg;
   typedef enum logic [2:0] {
      LRD_IDLE, LRD_ADDR, LRD_ACK_ADDR, LRD_WRITE, LRD_ACK_WRITE, LRD_READ, LRD_ACK_READ
   } lrd_bus_state_type;
   typedef enum logic [1:0] {LRD_STRAP_GND, LRD_STRAP_FLOAT, LRD_STRAP_VDD} lrd_strap_type;
endpackage

// [src/lrd_readout.sv]
// Dual channel light readout with two-wire slave
// Operation
// - Integration length is multiple times 918 oscillator cycles
// - One count per two periods, minus two
// - Counts saturate at 65535
// - Both channels integrate together, load together
// - Result words read low byte first in one read transfer never half updated
// - Next integration starts right after loading
// - Low gain divides sensitivity by sixteen
// - Slave address from three-level select pin
// - Alert response address always answered
// - Line held low 25 ms times out
// - Slave compatible with SMBus and fast I2C
// - Command byte MSB set selects register
// - Reads return currently selected register
`timescale 1ns/1ps
`include "lrd_regs.svh"
module lrd_readout
   import lrd_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = `LRD_TIMEOUT_MS * `LRD_CLK_KHZ
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Sensor side
   input wire logic osc_clk_in,
   input wire logic broadband_pulse_in,
   input wire logic infrared_pulse_in,
   input wire logic [1:0] integ_field_in,
   input wire logic low_gain_in,
   input wire logic [1:0] addr_sel_in,
   // Two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Results
   output logic [15:0] broadband_data_out,
   output logic [15:0] infrared_data_out,
   output logic conv_done_out
);
   // Synchronisers for bus, pulse, oscillator and address select inputs
   logic [6:0] s1_r, s2_r, s3_r;
   always_ff @(posedge sys_clk_in) begin
      s1_r <= {addr_sel_in, osc_clk_in, infrared_pulse_in, broadband_pulse_in, sda_in, scl_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
   end
   wire logic scl_s = s2_r[0];
   wire logic sda_s = s2_r[1];
   wire logic [1:0] pd_rise = s2_r[3:2] & ~s3_r[3:2];
   wire logic osc_rise = s2_r[4] & ~s3_r[4];

   // Integration length select
   logic [18:0] cyc_r;
   wire logic [18:0] mult = (integ_field_in == 2'b00) ? `LRD_MULT_00 :
                            (integ_field_in == 2'b01) ? `LRD_MULT_01 : `LRD_MULT_10;
   wire logic [18:0] limit = 19'(mult * `LRD_CYC_UNIT);
   wire logic int_end = osc_rise && (cyc_r == limit - 19'd1);
   wire logic slot = osc_rise & cyc_r[0];

   // Oscillator cycle counter, restarts itself
   logic done_r;
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         cyc_r <= 19'h00000;
         done_r <= 1'b0;
      end else begin
         cyc_r <= int_end ? 19'h00000 : (osc_rise ? cyc_r + 19'd1 : cyc_r);
         done_r <= int_end;
      end
   end
   assign conv_done_out = done_r;

   // Per channel accumulation and load
   logic [17:0] raw_r [2];
   logic [15:0] data_r [2];
   logic [3:0] pre_r [2];
   logic [1:0] pend_r;
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         wire logic take = slot & pend_r[ch];
         wire logic bump = take & (!low_gain_in || pre_r[ch] == `LRD_PRESCALE_LAST);
         wire logic [17:0] tot = raw_r[ch] + 18'(bump); // Last slot counts too
         wire logic [17:0] net = (tot < `LRD_CNT_OFFSET) ? 18'h00000 :
                                 tot - `LRD_CNT_OFFSET;
         wire logic [15:0] clamped = (net > `LRD_CNT_MAX) ? 16'hFFFF : net[15:0];
         always_ff @(posedge sys_clk_in) begin
            if (reset_in) begin
               raw_r[ch] <= 18'h00000;
               pre_r[ch] <= 4'h0;
               pend_r[ch] <= 1'b0;
               data_r[ch] <= 16'h0000;
            end else begin
               pend_r[ch] <= pd_rise[ch] | (pend_r[ch] & ~take);
               pre_r[ch] <= int_end ? 4'h0 : (take ? pre_r[ch] + 4'h1 : pre_r[ch]);
               raw_r[ch] <= int_end ? 18'h00000 : (bump ? raw_r[ch] + 18'd1 : raw_r[ch]);
               if (int_end) begin
                  data_r[ch] <= clamped;
               end
            end
         end
      end
   endgenerate
   assign broadband_data_out = data_r[0];
   assign infrared_data_out = data_r[1];

   // Address strap caught after reset release
   logic [1:0] strap_cnt_r;
   logic [6:0] own_addr_r;
   wire logic [6:0] strap_addr = (s2_r[6:5] == LRD_STRAP_GND) ? `LRD_ADDR_GND :
                                 (s2_r[6:5] == LRD_STRAP_FLOAT) ? `LRD_ADDR_FLOAT :
                                 `LRD_ADDR_VDD;
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         strap_cnt_r <= 2'd0;
         own_addr_r <= 7'h00;
      end else begin
         strap_cnt_r <= (strap_cnt_r == 2'd3) ? strap_cnt_r : strap_cnt_r + 2'd1;
         if (strap_cnt_r == 2'd2) begin
            own_addr_r <= strap_addr;
         end
      end
   end

   // Bus conditions and timeout
   logic scl_p_r, sda_p_r;
   logic [17:0] low_cnt_r;
   wire logic start_c = scl_s & scl_p_r & sda_p_r & ~sda_s;
   wire logic stop_c = scl_s & scl_p_r & ~sda_p_r & sda_s;
   wire logic scl_rise = scl_s & ~scl_p_r;
   wire logic scl_fall = ~scl_s & scl_p_r;
   wire logic tmo = (low_cnt_r == 18'(TIMEOUT_CYC));
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
         low_cnt_r <= 18'h00000;
      end else begin
         scl_p_r <= scl_s;
         sda_p_r <= sda_s;
         low_cnt_r <= (scl_s & sda_s) ? 18'h00000 : (tmo ? low_cnt_r : low_cnt_r + 18'd1);
      end
   end

   // Slave state machine
   lrd_bus_state_type state_r;
   logic [7:0] shift_r, tx_r, hi_r;
   logic [3:0] bit_r, sel_r;
   logic rw_r, ara_r, inc_r, hi_ok_r, nack_r, oe_r;
   wire logic hit_own = (shift_r[7:1] == own_addr_r);
   wire logic hit_ara = (shift_r[7:1] == `LRD_ARA_ADDR);
   wire logic [7:0] rd_byte = ara_r ? {own_addr_r, 1'b0} :
      (sel_r == `LRD_REG_D0L) ? data_r[0][7:0] :
      (sel_r == `LRD_REG_D0H) ? (hi_ok_r ? hi_r : data_r[0][15:8]) :
      (sel_r == `LRD_REG_D1L) ? data_r[1][7:0] :
      (sel_r == `LRD_REG_D1H) ? (hi_ok_r ? hi_r : data_r[1][15:8]) : 8'h00;
   wire logic low_sel = (sel_r == `LRD_REG_D0L) || (sel_r == `LRD_REG_D1L);
   wire logic [7:0] hi_live = (sel_r == `LRD_REG_D0L) ? data_r[0][15:8] : data_r[1][15:8];

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state_r <= LRD_IDLE;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         hi_r <= 8'h00;
         bit_r <= 4'd0;
         sel_r <= `LRD_SEL_RESET;
         rw_r <= 1'b0;
         ara_r <= 1'b0;
         inc_r <= 1'b0;
         hi_ok_r <= 1'b0;
         nack_r <= 1'b0;
      end else if (tmo) begin
         state_r <= LRD_IDLE;
      end else if (start_c) begin
         state_r <= LRD_ADDR;
         bit_r <= 4'd0;
         hi_ok_r <= 1'b0;
      end else if (stop_c) begin
         state_r <= LRD_IDLE;
      end else begin
         case (state_r)
            LRD_ADDR, LRD_WRITE: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_s};
                  bit_r <= bit_r + 4'd1;
               end else if (scl_fall && bit_r == 4'd8) begin
                  if (state_r == LRD_WRITE) begin
                     state_r <= LRD_ACK_WRITE;
                     if (shift_r[7]) begin
                        sel_r <= shift_r[3:0];
                        inc_r <= shift_r[5] | shift_r[4];
                     end
                  end else if (hit_own || hit_ara) begin
                     state_r <= LRD_ACK_ADDR;
                     rw_r <= shift_r[0];
                     ara_r <= hit_ara & ~hit_own;
                  end else begin
                     state_r <= LRD_IDLE;
                  end
               end
            end
            LRD_ACK_ADDR, LRD_ACK_WRITE, LRD_ACK_READ: begin
               if (scl_rise) begin
                  nack_r <= sda_s;
               end else if (scl_fall) begin
                  bit_r <= 4'd0;
                  if (state_r == LRD_ACK_READ && nack_r) begin
                     state_r <= LRD_IDLE;
                  end else if (state_r == LRD_ACK_WRITE || !rw_r) begin
                     state_r <= LRD_WRITE;
                  end else begin
                     state_r <= LRD_READ;
                     tx_r <= rd_byte;
                     if (low_sel) begin
                        hi_r <= hi_live;
                     end
                     hi_ok_r <= low_sel;
                  end
               end
            end
            LRD_READ: begin
               if (scl_fall) begin
                  tx_r <= {tx_r[6:0], 1'b0};
                  bit_r <= bit_r + 4'd1;
                  if (bit_r == 4'd7) begin
                     state_r <= LRD_ACK_READ;
                     if (inc_r && !ara_r) begin
                        sel_r <= sel_r + 4'd1; // Next byte sees new select
                     end
                  end
               end
            end
            default: state_r <= LRD_IDLE;
         endcase
      end
   end

   // Open-drain data drive
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= (state_r == LRD_ACK_ADDR) || (state_r == LRD_ACK_WRITE) ||
                 (state_r == LRD_READ && !tx_r[7]);
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe_out = oe_r;

   // Checks
   integ_end_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      osc_rise && cyc_r == limit - 19'd1 |=> done_r && cyc_r == 19'h00000)
      else $error("integration did not end at limit");
   full_scale_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      done_r |-> (broadband_data_out <= 16'(($past(limit) >> 1) - 19'd2)) ||
                 ($past(limit) > 19'd131074))
      else $error("count above half cycles minus two");
   clamp_sat_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      int_end && raw_r[0] > 18'd65537 |=> broadband_data_out == 16'hFFFF)
      else $error("count did not saturate");
   data_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !int_end |=> $stable(broadband_data_out) && $stable(infrared_data_out))
      else $error("result changed outside load");
   restart_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      done_r |-> cyc_r == 19'h00000 && raw_r[0] == 18'h00000 && raw_r[1] == 18'h00000)
      else $error("no restart after load");
   low_gain_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      low_gain_in && !int_end && slot && pend_r[0] && pre_r[0] != 4'hF
      |=> $stable(raw_r[0]))
      else $error("low gain counted early");
   strap_addr_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      strap_cnt_r == 2'd2 && s2_r[6:5] == 2'b01 |=> own_addr_r == 7'h39)
      else $error("floating select address wrong");
   ara_ack_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      state_r == LRD_ADDR && scl_fall && bit_r == 4'd8 && hit_ara && !start_c && !stop_c
      && !tmo |=> state_r == LRD_ACK_ADDR ##1 oe_r)
      else $error("alert address not acknowledged");
   bus_tmo_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      tmo |=> state_r == LRD_IDLE ##1 !oe_r)
      else $error("timeout did not release bus");
   cmd_sel_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      state_r == LRD_WRITE && scl_fall && bit_r == 4'd8 && shift_r[7] && !start_c
      && !stop_c && !tmo |=> sel_r == $past(shift_r[3:0]))
      else $error("command byte not stored");
   done_pulse_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      done_r |=> !done_r)
      else $error("done longer than one cycle");
endmodule // lrd_readout

// [test/lrd_host_model.sv]
// Two-wire bus master model facing the readout's slave port
`timescale 1ns/1ps
module lrd_host_model (
   // Clock
   input wire logic sys_clk_in,
   // Bus lines
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   // Bus idles released
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // Whole clocks, lines move only after falling edges
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask
   // Start or repeated start
   task automatic frame_start();
      sda_low_out = 1'b0;
      idle(8);
      scl_out = 1'b1;
      idle(8);
      sda_low_out = 1'b1;
      idle(8);
      scl_out = 1'b0;
      idle(8);
   endtask
   // Stop, SDA rises with SCL high
   task automatic frame_stop();
      sda_low_out = 1'b1;
      idle(8);
      scl_out = 1'b1;
      idle(8);
      sda_low_out = 1'b0;
      idle(8);
   endtask
   // Eight bits MSB first, then the ninth; FF releases SDA to read
   task automatic send(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                       output logic ack);
      for (int i = 8; i >= 0; i--) begin
         sda_low_out = (i == 0) ? mack : !tx[i-1];
         idle(8);
         scl_out = 1'b1;
         idle(9);
         if (i == 0) ack = !sda_in;
         else rx[i-1] = sda_in;
         scl_out = 1'b0;
         idle(8);
      end
   endtask
   // Address byte with direction bit appended
   task automatic send_addr(input logic [6:0] a, input logic rd, output logic ack);
      logic [7:0] rx;
      send({a, rd}, 1'b0, rx, ack);
   endtask
endmodule // lrd_host_model

// [test/tb.sv]
// Self-checking testbench for the dual channel light readout
`timescale 1ns/1ps
module tb;
   import lrd_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic osc = 1'b0;
   logic bb_pulse = 1'b0;
   logic low_gain = 1'b0;
   logic [1:0] integ_field = 2'b00;
   logic [1:0] addr_sel = 2'b00;
   logic scl, sda_low, sda_out, sda_oe, conv_done;
   logic [15:0] bb_data, ir_data;
   logic [15:0] full = 16'((11 * 918) / 2 - 2);
   wire logic sda_line = !(sda_low | (sda_oe & !sda_out));
   int n_mismatch = 0;
   int n_checks = 0;
   // Clocks; pulses outpace the counting rate
   initial forever #50 sys_clk = ~sys_clk;
   always #400 osc = ~osc;
   always #200 bb_pulse = ~bb_pulse;
   // Design and bus master
   lrd_readout #(.TIMEOUT_CYC(200)) i_lrd_readout (.sys_clk_in(sys_clk), .reset_in(reset),
      .osc_clk_in(osc), .broadband_pulse_in(bb_pulse), .infrared_pulse_in(1'b0),
      .integ_field_in(integ_field), .low_gain_in(low_gain), .addr_sel_in(addr_sel), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe),
      .broadband_data_out(bb_data), .infrared_data_out(ir_data), .conv_done_out(conv_done));
   lrd_host_model i_lrd_host_model (.sys_clk_in(sys_clk), .sda_in(sda_line), .scl_out(scl),
      .sda_low_out(sda_low));
   // Compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Foreign address ignored, alert and own address answered
   task automatic t_address();
      logic [7:0] rx;
      logic ack;
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h39, 1'b0, ack);
      check("foreign ack", 16'(ack), 16'h0000);
      i_lrd_host_model.frame_stop();
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h0C, 1'b1, ack);
      check("alert ack", 16'(ack), 16'h0001);
      i_lrd_host_model.send(8'hFF, 1'b0, rx, ack);
      check("alert data", 16'(rx), 16'h0052);
      i_lrd_host_model.frame_stop();
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h29, 1'b0, ack);
      check("own ack", 16'(ack), 16'h0001);
      i_lrd_host_model.frame_stop();
   endtask
   // Master stalls SCL while device drives a zero bit
   task automatic t_timeout();
      logic ack;
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h29, 1'b1, ack);
      i_lrd_host_model.idle(20);
      check("zero bit driven", 16'(sda_oe), 16'h0001);
      i_lrd_host_model.idle(250);
      check("released after timeout", 16'(sda_oe), 16'h0000);
      i_lrd_host_model.frame_stop();
   endtask
   // First conversion at full scale, pulse one cycle
   task automatic t_convert();
      int k;
      k = 0;
      while (conv_done !== 1'b1 && k < 90000) begin
         @(negedge sys_clk);
         k++;
      end
      check("done pulse", 16'(conv_done), 16'h0001);
      check("broadband count", bb_data, full);
      check("infrared count", ir_data, 16'h0000);
      @(negedge sys_clk);
      check("done one cycle", 16'(conv_done), 16'h0000);
      check("broadband holds", bb_data, full);
   endtask
   // Word read with increment, then a plain select and an ignored data byte
   task automatic t_read();
      logic [7:0] rx;
      logic ack;
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h29, 1'b0, ack);
      i_lrd_host_model.send(8'hAC, 1'b0, rx, ack);
      check("command ack", 16'(ack), 16'h0001);
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h29, 1'b1, ack);
      i_lrd_host_model.send(8'hFF, 1'b1, rx, ack);
      check("low byte", 16'(rx), 16'(full[7:0]));
      i_lrd_host_model.send(8'hFF, 1'b0, rx, ack);
      check("high byte", 16'(rx), 16'(full[15:8]));
      i_lrd_host_model.frame_stop();
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h29, 1'b0, ack);
      i_lrd_host_model.send(8'h8D, 1'b0, rx, ack);
      i_lrd_host_model.send(8'h3C, 1'b0, rx, ack);
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h29, 1'b1, ack);
      i_lrd_host_model.send(8'hFF, 1'b0, rx, ack);
      check("selected high", 16'(rx), 16'(full[15:8]));
      i_lrd_host_model.frame_stop();
   endtask
   // Reset again mid-run with the select pin floating
   task automatic t_restart();
      logic ack;
      addr_sel = 2'b01;
      reset = 1'b1;
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      repeat (4) @(negedge sys_clk);
      check("data after reset", bb_data, 16'h0000);
      check("done after reset", 16'(conv_done), 16'h0000);
      check("oe after reset", 16'(sda_oe), 16'h0000);
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h29, 1'b0, ack);
      check("old address ignored", 16'(ack), 16'h0000);
      i_lrd_host_model.frame_stop();
      i_lrd_host_model.frame_start();
      i_lrd_host_model.send_addr(7'h39, 1'b0, ack);
      check("float address ack", 16'(ack), 16'h0001);
      i_lrd_host_model.frame_stop();
   endtask
   // Verdict
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog past one full conversion
   initial begin
      #9_500_000;
      n_mismatch++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      repeat (4) @(negedge sys_clk);
      t_address();
      t_timeout();
      t_convert();
      low_gain = 1'b1;
      integ_field = 2'b10;
      t_read();
      t_restart();
      tally_and_finish();
   end
endmodule // tb
